// >>> hw/conv_pkg.sv
// constants, types and enumerations shared by the converter control block
// What this block does
// - first enable set only powers converter up
// - second enable set after settling starts conversion
// - clearing enable aborts and powers down
// - power-down-done flag readable after disable
// - ready flag reports power-up complete
// - disabled or reset means held powered down
// - injected sequence up to 4, length [21:20]
// - regular sequence up to 16, length [23:20]
// - any channel in either sequence, repeats allowed
// - sixteen channels, twelve external, four internal
// - 12-bit result left or right aligned
// - events for regular end, injected end, threshold
// - single, continuous, scan and discontinuous modes
// - working clock from divided bus or PLL
// - PLL divider ratios 1 through 256
// - bus divider ratios 1 through 32
// - separate selectable triggers for each sequence
// - sampling interval programmable per channel
// - bus source gives fixed trigger latency
package conv_pkg;
  localparam int CLK_MHZ = 100;
  localparam int NUM_CH = 16;
  localparam int NUM_EXT_CH = 12;
  localparam int RES_BITS = 12;
  localparam int DATA_BITS = 16;
  localparam int INJ_MAX = 4;
  localparam int REG_MAX = 16;
  localparam int INJ_LEN_LSB = 20;
  localparam int INJ_LEN_MSB = 21;
  localparam int REG_LEN_LSB = 20;
  localparam int REG_LEN_MSB = 23;
  localparam int CH_FIELD = 4;
  localparam int SEQ1_FIRST_POS = 12;
  localparam int SEQ3_FIRST_POS = 8;
  localparam int SMP_FIELD = 3;
  localparam int BUS_DIV_MAX_CODE = 9;
  localparam int PLL_DIV_MAX_CODE = 12;
  localparam int FIFO_DEPTH = 16;
  localparam logic [15:0] RESET_DATA = 16'h0000;
  localparam int STAB_US_DEFAULT = 1;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_WAKE = 2'b01,
    PWR_ON = 2'b10
  } pwr_state_t;

  typedef enum logic [2:0] {
    CV_IDLE = 3'b000,
    CV_SAMPLE = 3'b001,
    CV_CONVERT = 3'b010,
    CV_STORE = 3'b011
  } conv_state_t;

  typedef struct packed {
    logic [3:0] channel;
    logic [15:0] data;
  } result_t;

  typedef struct packed {
    logic continuous;
    logic scan;
    logic discontinuous;
    logic [2:0] disc_count;
    logic align_left;
  } mode_t;
endpackage

// >>> hw/result_fifo.sv
// result buffer with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("result_fifo depth must be a power of two");
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;
  assign in_ready = (wr_r ^ rd_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_r != rd_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_r[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_r[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (push)
        wr_r <= wr_r + 1'b1;
      if (pop)
        rd_r <= rd_r + 1'b1;
    end
  end
endmodule

// >>> hw/conv_ctrl.sv
// converter control: power sequencing, clocking, sequences and results
`timescale 1ns/1ps
module conv_ctrl #(
  parameter int STAB_US = conv_pkg::STAB_US_DEFAULT,
  parameter int DEPTH = conv_pkg::FIFO_DEPTH
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic ON_WR,
  input wire logic ON_WDATA,
  input wire logic CLK_SRC_PLL,
  input wire logic [3:0] CLK_DIV_SEL,
  input wire logic PLL_CLK,
  input wire logic MICROSECOND_TICK_CLOCK,
  input wire conv_pkg::mode_t MODE,
  input wire logic [31:0] FIRST_REGULAR_SEQUENCE_REG,
  input wire logic [31:0] REGULAR_SEQUENCE_REG2,
  input wire logic [31:0] REGULAR_SEQUENCE_REG3,
  input wire logic [31:0] INJECTED_SEQUENCE_REG,
  input wire logic [47:0] SAMPLE_TIME,
  input wire logic [7:0] EXT_TRIG,
  input wire logic REG_TRIG_EN,
  input wire logic [2:0] REG_TRIG_SEL,
  input wire logic INJ_TRIG_EN,
  input wire logic [2:0] INJ_TRIG_SEL,
  input wire logic AWD_EN,
  input wire logic [11:0] AWD_HIGH,
  input wire logic [11:0] AWD_LOW,
  output logic READY_FLAG,
  output logic POWER_DOWN_DONE_FLAG,
  output logic BUSY,
  output logic ANA_POWER_ON,
  output logic ANA_SAMPLE,
  output logic ANA_CONVERT,
  output logic [3:0] ANA_CHANNEL,
  input wire logic ANA_DONE,
  input wire logic [11:0] ANA_DATA,
  output logic END_REG_EVT,
  output logic END_INJ_EVT,
  output logic AWD_EVT,
  output logic [63:0] INJ_DATA,
  output logic RES_VALID,
  input wire logic RES_READY,
  output conv_pkg::result_t RES_DATA
);
  import conv_pkg::*;

  localparam int STAB_CNT_W = $clog2(STAB_US + 1) + 1;
  if (STAB_US < 1)
    $error("stabilisation delay must be at least one microsecond");

  function automatic logic [8:0] div_ratio(input logic [3:0] code, input logic pll);
    logic [3:0] c;
    c = (!pll && code > 4'(BUS_DIV_MAX_CODE)) ? 4'(BUS_DIV_MAX_CODE) : code;
    if (pll && c > 4'(PLL_DIV_MAX_CODE))
      c = 4'(PLL_DIV_MAX_CODE);
    case (c)
      4'h0: div_ratio = 9'h001;
      4'h1: div_ratio = 9'h002;
      4'h2: div_ratio = 9'h003;
      4'h3: div_ratio = 9'h004;
      4'h4: div_ratio = 9'h006;
      4'h5: div_ratio = 9'h008;
      4'h6: div_ratio = 9'h00a;
      4'h7: div_ratio = 9'h00c;
      4'h8: div_ratio = 9'h010;
      4'h9: div_ratio = 9'h020;
      4'ha: div_ratio = 9'h040;
      4'hb: div_ratio = 9'h080;
      default: div_ratio = 9'h100;
    endcase
  endfunction

  function automatic logic [3:0] reg_channel(input logic [3:0] idx);
    if (idx >= 4'(SEQ1_FIRST_POS))
      reg_channel = FIRST_REGULAR_SEQUENCE_REG[CH_FIELD*(idx-4'(SEQ1_FIRST_POS)) +: CH_FIELD];
    else if (idx >= 4'(SEQ3_FIRST_POS))
      reg_channel = REGULAR_SEQUENCE_REG3[CH_FIELD*(idx-4'(SEQ3_FIRST_POS)) +: CH_FIELD];
    else
      reg_channel = REGULAR_SEQUENCE_REG2[CH_FIELD*idx +: CH_FIELD];
  endfunction

  logic pll_s1_r;
  logic pll_s2_r;
  logic pll_d_r;
  logic us_s1_r;
  logic us_s2_r;
  logic us_d_r;
  logic [7:0] trg_s1_r;
  logic [7:0] trg_s2_r;
  logic reg_trg_d_r;
  logic inj_trg_d_r;
  logic [8:0] div_cnt_r;
  logic tick;
  logic src_event;
  logic us_tick;
  logic [7:0] trg_view;
  logic reg_trg_lvl;
  logic inj_trg_lvl;
  logic reg_trg_edge;
  logic inj_trg_edge;

  // pll clock is slow relative to CLOCK, counted by its synchronised edges
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      pll_s1_r <= 1'b0;
      pll_s2_r <= 1'b0;
      pll_d_r <= 1'b0;
      us_s1_r <= 1'b0;
      us_s2_r <= 1'b0;
      us_d_r <= 1'b0;
      trg_s1_r <= 8'h00;
      trg_s2_r <= 8'h00;
    end
    else
    begin
      pll_s1_r <= PLL_CLK;
      pll_s2_r <= pll_s1_r;
      pll_d_r <= pll_s2_r;
      us_s1_r <= MICROSECOND_TICK_CLOCK;
      us_s2_r <= us_s1_r;
      us_d_r <= us_s2_r;
      trg_s1_r <= EXT_TRIG;
      trg_s2_r <= trg_s1_r;
    end
  end

  assign us_tick = us_s2_r && !us_d_r;
  assign src_event = CLK_SRC_PLL ? (pll_s2_r && !pll_d_r) : 1'b1;
  assign tick = src_event && (div_cnt_r >= div_ratio(CLK_DIV_SEL, CLK_SRC_PLL) - 9'h001);

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      div_cnt_r <= 9'h000;
    // with the bus source, idle restarts the divider so a start always sees the same phase
    else if (tick || (!BUSY && !CLK_SRC_PLL))
      div_cnt_r <= 9'h000;
    else if (src_event)
      div_cnt_r <= div_cnt_r + 9'h001;
  end

  // bus source skips the synchroniser so trigger latency stays fixed
  assign trg_view = CLK_SRC_PLL ? trg_s2_r : EXT_TRIG;
  assign reg_trg_lvl = trg_view[REG_TRIG_SEL];
  assign inj_trg_lvl = trg_view[INJ_TRIG_SEL];
  assign reg_trg_edge = REG_TRIG_EN && reg_trg_lvl && !reg_trg_d_r;
  assign inj_trg_edge = INJ_TRIG_EN && inj_trg_lvl && !inj_trg_d_r;

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      reg_trg_d_r <= 1'b0;
      inj_trg_d_r <= 1'b0;
    end
    else
    begin
      reg_trg_d_r <= reg_trg_lvl;
      inj_trg_d_r <= inj_trg_lvl;
    end
  end

  pwr_state_t pwr_r;
  logic [STAB_CNT_W-1:0] stab_r;
  logic sw_start;

  // a set while waking is dropped; software must wait for the ready flag
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      pwr_r <= PWR_OFF;
      stab_r <= '0;
    end
    else if (ON_WR && !ON_WDATA)
      pwr_r <= PWR_OFF;
    else
    begin
      case (pwr_r)
        PWR_OFF:
        begin
          stab_r <= '0;
          if (ON_WR && ON_WDATA)
            pwr_r <= PWR_WAKE;
        end
        PWR_WAKE:
        begin
          if (us_tick)
            stab_r <= stab_r + 1'b1;
          if (stab_r >= STAB_CNT_W'(STAB_US))
            pwr_r <= PWR_ON;
        end
        PWR_ON:
          pwr_r <= PWR_ON;
        default:
          pwr_r <= PWR_OFF;
      endcase
    end
  end

  assign sw_start = (pwr_r == PWR_ON) && ON_WR && ON_WDATA;
  assign READY_FLAG = pwr_r == PWR_ON;
  assign POWER_DOWN_DONE_FLAG = pwr_r == PWR_OFF;
  assign ANA_POWER_ON = pwr_r != PWR_OFF;

  conv_state_t cv_r;
  logic inj_mode_r;
  logic reg_pend_r;
  logic reg_act_r;
  logic inj_pend_r;
  logic [3:0] reg_idx_r;
  logic [1:0] inj_idx_r;
  logic [2:0] disc_r;
  logic [7:0] cnt_r;
  logic [3:0] ch_r;
  logic [11:0] raw_r;
  logic [15:0] inj_data_r [INJ_MAX];
  logic end_reg_r;
  logic end_inj_r;
  logic awd_r;
  logic fifo_ready;
  logic fifo_push;
  logic [15:0] aligned;
  logic [3:0] reg_len;
  logic [1:0] inj_len;
  logic [3:0] next_ch;
  logic reg_last;
  logic run;

  assign run = pwr_r == PWR_ON;
  assign reg_len = MODE.scan ? FIRST_REGULAR_SEQUENCE_REG[REG_LEN_MSB:REG_LEN_LSB] : 4'h0;
  assign inj_len = INJECTED_SEQUENCE_REG[INJ_LEN_MSB:INJ_LEN_LSB];
  assign next_ch = inj_pend_r ? INJECTED_SEQUENCE_REG[CH_FIELD*inj_idx_r +: CH_FIELD]
                              : reg_channel(reg_idx_r);
  assign reg_last = reg_idx_r == reg_len;
  assign aligned = MODE.align_left ? {raw_r, 4'h0} : {4'h0, raw_r};
  assign fifo_push = (cv_r == CV_STORE) && !inj_mode_r;

  // injected work is picked between conversions, so regular resumes in place
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N || !run || (ON_WR && !ON_WDATA))
    begin
      cv_r <= CV_IDLE;
      inj_mode_r <= 1'b0;
      reg_pend_r <= 1'b0;
      reg_act_r <= 1'b0;
      inj_pend_r <= 1'b0;
      reg_idx_r <= 4'h0;
      inj_idx_r <= 2'b00;
      disc_r <= 3'b000;
      cnt_r <= 8'h00;
      ch_r <= 4'h0;
      raw_r <= 12'h000;
    end
    else
    begin
      if (sw_start || reg_trg_edge)
        reg_pend_r <= 1'b1;
      if (inj_trg_edge)
        inj_pend_r <= 1'b1;
      case (cv_r)
        CV_IDLE:
        begin
          if (inj_pend_r || reg_pend_r || reg_act_r)
          begin
            inj_mode_r <= inj_pend_r;
            if (!inj_pend_r)
            begin
              reg_act_r <= 1'b1;
              reg_pend_r <= sw_start || reg_trg_edge;
            end
            ch_r <= next_ch;
            cnt_r <= 8'h00;
            cv_r <= CV_SAMPLE;
          end
        end
        CV_SAMPLE:
        begin
          if (tick)
            cnt_r <= cnt_r + 8'h01;
          if (tick && cnt_r >= (8'h01 << SAMPLE_TIME[SMP_FIELD*ch_r +: SMP_FIELD]) - 8'h01)
            cv_r <= CV_CONVERT;
        end
        CV_CONVERT:
        begin
          if (ANA_DONE)
          begin
            raw_r <= ANA_DATA;
            cv_r <= CV_STORE;
          end
        end
        CV_STORE:
        begin
          if (inj_mode_r)
          begin
            cv_r <= CV_IDLE;
            inj_idx_r <= (inj_idx_r == inj_len) ? 2'b00 : inj_idx_r + 2'b01;
            if (inj_idx_r == inj_len && !inj_trg_edge)
              inj_pend_r <= 1'b0;
          end
          else if (fifo_ready)
          begin
            cv_r <= CV_IDLE;
            reg_idx_r <= reg_last ? 4'h0 : reg_idx_r + 4'h1;
            disc_r <= disc_r + 3'b001;
            if (reg_last && !MODE.continuous)
              reg_act_r <= 1'b0;
            if (MODE.discontinuous && disc_r >= MODE.disc_count)
            begin
              reg_act_r <= 1'b0;
              disc_r <= 3'b000;
            end
          end
        end
        default:
          cv_r <= CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < INJ_MAX; i++)
        inj_data_r[i] <= RESET_DATA;
    end
    else if (cv_r == CV_STORE && inj_mode_r)
      inj_data_r[inj_idx_r] <= aligned;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      end_reg_r <= 1'b0;
      end_inj_r <= 1'b0;
      awd_r <= 1'b0;
    end
    else
    begin
      end_reg_r <= fifo_push && fifo_ready;
      end_inj_r <= cv_r == CV_STORE && inj_mode_r && inj_idx_r == inj_len;
      // thresholds compare the raw code, before alignment
      awd_r <= AWD_EN && (fifo_push ? fifo_ready : cv_r == CV_STORE)
               && (raw_r > AWD_HIGH || raw_r < AWD_LOW);
    end
  end

  assign END_REG_EVT = end_reg_r;
  assign END_INJ_EVT = end_inj_r;
  assign AWD_EVT = awd_r;
  assign BUSY = cv_r != CV_IDLE;
  assign ANA_SAMPLE = cv_r == CV_SAMPLE;
  assign ANA_CONVERT = cv_r == CV_CONVERT;
  assign ANA_CHANNEL = ch_r;
  assign INJ_DATA = {inj_data_r[3], inj_data_r[2], inj_data_r[1], inj_data_r[0]};

  // a full buffer holds a regular conversion in the store state
  result_fifo #(
    .WIDTH($bits(result_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .in_valid(fifo_push),
    .in_ready(fifo_ready),
    .in_data({ch_r, aligned}),
    .out_valid(RES_VALID),
    .out_ready(RES_READY),
    .out_data(RES_DATA)
  );
endmodule

// >>> dv/ana_core_model.sv
// behavioural model of the analog sampling core
`timescale 1ns/1ps
module ana_core_model (
  input wire logic clk,
  input wire logic power_on,
  input wire logic convert,
  input wire logic [3:0] channel,
  input wire logic slow,
  output logic done,
  output logic [11:0] data
);
  logic [4:0] cnt_r = 5'h00;
  logic [11:0] last_r = 12'h000;
  always_ff @(posedge clk)
  begin
    done <= 1'b0;
    data <= ~last_r; // no stale value outside the answer cycle
    if (!convert || !power_on)
      cnt_r <= 5'h00;
    else if (cnt_r != 5'h1f)
    begin
      cnt_r <= cnt_r + 5'h01;
      if (cnt_r == (slow ? 5'h14 : 5'h02))
      begin
        done <= 1'b1;
        data <= {channel, 8'ha5};
        last_r <= {channel, 8'ha5};
      end
    end
  end
endmodule

// >>> dv/conv_ctrl_props.sv
// checker for the converter control block ports
`timescale 1ns/1ps
module conv_ctrl_props (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic ON_WR,
  input wire logic ON_WDATA,
  input wire logic READY_FLAG,
  input wire logic POWER_DOWN_DONE_FLAG,
  input wire logic BUSY,
  input wire logic ANA_POWER_ON,
  input wire logic ANA_SAMPLE,
  input wire logic ANA_CONVERT,
  input wire logic [3:0] ANA_CHANNEL,
  input wire logic END_REG_EVT,
  input wire logic RES_VALID,
  input wire logic RES_READY,
  input wire conv_pkg::result_t RES_DATA
);
  import conv_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  a_reset_powered_down: assert property ($rose(RESET_N) |-> POWER_DOWN_DONE_FLAG && !READY_FLAG && !BUSY)
    else $error("not powered down after reset");
  a_clear_powers_off: assert property (ON_WR && !ON_WDATA |=> POWER_DOWN_DONE_FLAG && !BUSY && !ANA_POWER_ON)
    else $error("clear did not power down");
  a_first_set_wakes: assert property (ON_WR && ON_WDATA && POWER_DOWN_DONE_FLAG |=> ANA_POWER_ON && !BUSY)
    else $error("first set misbehaved");
  a_second_set_starts: assert property (ON_WR && ON_WDATA && READY_FLAG && !BUSY |=> ##1 BUSY && ANA_SAMPLE)
    else $error("second set did not start");
  a_busy_needs_ready: assert property (BUSY |-> READY_FLAG)
    else $error("busy while not ready");
  a_flags_exclusive: assert property (!(READY_FLAG && POWER_DOWN_DONE_FLAG))
    else $error("ready and powered down together");
  a_done_tracks_power: assert property (POWER_DOWN_DONE_FLAG == !ANA_POWER_ON)
    else $error("power flag disagrees with core power");
  a_channel_held: assert property (ANA_SAMPLE ##1 ANA_SAMPLE |-> $stable(ANA_CHANNEL))
    else $error("channel moved while sampling");
  a_sample_then_convert: assert property ($fell(ANA_SAMPLE) && BUSY |-> ANA_CONVERT)
    else $error("no convert after sample");
  a_end_evt_pulse: assert property (END_REG_EVT |=> !END_REG_EVT)
    else $error("end event longer than a cycle");
  a_result_held: assert property (RES_VALID && !RES_READY |=> RES_VALID && $stable(RES_DATA))
    else $error("result dropped while stalled");
  c_second_set: cover property (ON_WR && ON_WDATA && READY_FLAG);
  c_stalled_busy: cover property (RES_VALID && !RES_READY && BUSY);
  c_run_end: cover property ($fell(BUSY) && ANA_POWER_ON);
endmodule
bind conv_ctrl conv_ctrl_props u_props (.CLOCK, .RESET_N, .ON_WR, .ON_WDATA, .READY_FLAG, .POWER_DOWN_DONE_FLAG,
  .BUSY, .ANA_POWER_ON, .ANA_SAMPLE, .ANA_CONVERT, .ANA_CHANNEL, .END_REG_EVT, .RES_VALID, .RES_READY, .RES_DATA);

// >>> dv/conv_ctrl_tb_top.sv
// testbench for the converter control block
`timescale 1ns/1ps
module conv_ctrl_tb_top;
  import conv_pkg::*;
  logic CLOCK = 1'b0, RESET_N = 1'b0, ON_WR = 1'b0, ON_WDATA = 1'b0, PLL_CLK = 1'b0, TICK = 1'b0;
  logic REG_TRIG_EN = 1'b0, INJ_TRIG_EN = 1'b0, AWD_EN = 1'b0, RES_READY = 1'b0, SLOW = 1'b0;
  logic [2:0] REG_TRIG_SEL = 3'h0, INJ_TRIG_SEL = 3'h0;
  logic [3:0] CLK_DIV_SEL = 4'h0;
  logic [7:0] EXT_TRIG = 8'h00;
  logic [11:0] AWD_HIGH = 12'hfff;
  logic [31:0] SEQ1 = 32'h0020_0000, SEQ2 = 32'h0000_3a53, INJ = 32'h0030_dc21;
  logic [47:0] SAMPLE_TIME = 48'h0;
  mode_t MODE = mode_t'(7'h00);
  logic READY_FLAG, POWER_DOWN_DONE_FLAG, BUSY, ANA_POWER_ON, ANA_SAMPLE, ANA_CONVERT, ANA_DONE;
  logic END_REG_EVT, END_INJ_EVT, AWD_EVT, RES_VALID;
  logic [3:0] ANA_CHANNEL;
  logic [11:0] ANA_DATA;
  logic [63:0] INJ_DATA;
  result_t RES_DATA;
  int error_cnt = 0, comparisons = 0, evt_cnt = 0, awd_cnt = 0, goal = 0, n, i;
  conv_ctrl uut (.CLOCK(CLOCK), .RESET_N(RESET_N), .ON_WR(ON_WR), .ON_WDATA(ON_WDATA), .CLK_SRC_PLL(1'b0),
    .CLK_DIV_SEL(CLK_DIV_SEL), .PLL_CLK(PLL_CLK), .MICROSECOND_TICK_CLOCK(TICK), .MODE(MODE),
    .FIRST_REGULAR_SEQUENCE_REG(SEQ1), .REGULAR_SEQUENCE_REG2(SEQ2), .REGULAR_SEQUENCE_REG3(32'h0),
    .INJECTED_SEQUENCE_REG(INJ), .SAMPLE_TIME(SAMPLE_TIME), .EXT_TRIG(EXT_TRIG), .REG_TRIG_EN(REG_TRIG_EN),
    .REG_TRIG_SEL(REG_TRIG_SEL), .INJ_TRIG_EN(INJ_TRIG_EN), .INJ_TRIG_SEL(INJ_TRIG_SEL), .AWD_EN(AWD_EN),
    .AWD_HIGH(AWD_HIGH), .AWD_LOW(12'h000), .READY_FLAG(READY_FLAG), .POWER_DOWN_DONE_FLAG(POWER_DOWN_DONE_FLAG),
    .BUSY(BUSY), .ANA_POWER_ON(ANA_POWER_ON), .ANA_SAMPLE(ANA_SAMPLE), .ANA_CONVERT(ANA_CONVERT),
    .ANA_CHANNEL(ANA_CHANNEL), .ANA_DONE(ANA_DONE), .ANA_DATA(ANA_DATA), .END_REG_EVT(END_REG_EVT),
    .END_INJ_EVT(END_INJ_EVT), .AWD_EVT(AWD_EVT), .INJ_DATA(INJ_DATA), .RES_VALID(RES_VALID),
    .RES_READY(RES_READY), .RES_DATA(RES_DATA));
  ana_core_model core (.clk(CLOCK), .power_on(ANA_POWER_ON), .convert(ANA_CONVERT), .channel(ANA_CHANNEL),
    .slow(SLOW), .done(ANA_DONE), .data(ANA_DATA));
  initial
  begin
    forever #5 CLOCK = ~CLOCK;
  end
  always #500 TICK = ~TICK;
  always #27 PLL_CLK = ~PLL_CLK;
  always @(posedge CLOCK)
  begin
    evt_cnt <= evt_cnt + (END_REG_EVT === 1'b1);
    awd_cnt <= awd_cnt + (AWD_EVT === 1'b1);
  end
  task results;
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bounded wait: 0 ready, 1 result, 2 idle, 3 event goal, 4 injected end
  task automatic wt(input int s);
    for (int k = 0; k < 3000; k++)
    begin
      @(posedge CLOCK);
      #1;
      if ((s == 0 && READY_FLAG === 1'b1) || (s == 1 && RES_VALID === 1'b1) || (s == 2 && BUSY === 1'b0) ||
          (s == 3 && evt_cnt >= goal) || (s == 4 && END_INJ_EVT === 1'b1))
        return;
    end
    error_cnt++;
    results();
  endtask
  task on(input logic v);
    @(posedge CLOCK);
    ON_WR <= 1'b1;
    ON_WDATA <= v;
    @(posedge CLOCK);
    ON_WR <= 1'b0;
    #1;
  endtask
  task pop(input logic [3:0] ch, input logic left);
    wt(1);
    chk(RES_DATA, left ? {ch, ch, 8'ha5, 4'h0} : {ch, 4'h0, ch, 8'ha5});
    @(posedge CLOCK);
    RES_READY <= 1'b1;
    @(posedge CLOCK);
    RES_READY <= 1'b0;
  endtask
  task trig(input logic [7:0] t);
    @(posedge CLOCK);
    EXT_TRIG <= t;
    @(posedge CLOCK);
    EXT_TRIG <= 8'h00;
  endtask
  initial
  begin
    repeat (6) @(posedge CLOCK);
    RESET_N <= 1'b1;
    #1;
    chk(POWER_DOWN_DONE_FLAG, 1'b1);
    chk(READY_FLAG, 1'b0);
    on(1'b1);
    chk(POWER_DOWN_DONE_FLAG, 1'b0);
    chk(ANA_POWER_ON, 1'b1);
    wt(0);
    chk(BUSY, 1'b0);
    on(1'b1);
    @(posedge CLOCK);
    #1;
    chk(BUSY, 1'b1);
    chk(ANA_CHANNEL, 4'h3);
    pop(4'h3, 1'b0);
    wt(2);
    chk(RES_VALID, 1'b0);
    // sequences change only while idle
    @(posedge CLOCK);
    MODE <= mode_t'(7'b0100001);
    on(1'b1);
    wt(2);
    pop(4'h3, 1'b1);
    pop(4'h5, 1'b1);
    pop(4'ha, 1'b1);
    @(posedge CLOCK);
    #1;
    chk(RES_VALID, 1'b0);
    // continuous run with a slow core fills the buffer, then a clear aborts it mid-conversion
    MODE <= mode_t'(7'b1100001);
    SLOW <= 1'b1;
    goal = evt_cnt + 16;
    on(1'b1);
    wt(3);
    @(posedge CLOCK);
    #1;
    chk(BUSY, 1'b1);
    on(1'b0);
    chk(BUSY, 1'b0);
    chk(POWER_DOWN_DONE_FLAG, 1'b1);
    for (i = 0; i < 16; i++)
      pop(i % 3 == 0 ? 4'h3 : (i % 3 == 1 ? 4'h5 : 4'ha), 1'b1);
    @(posedge CLOCK);
    #1;
    chk(RES_VALID, 1'b0);
    MODE <= mode_t'(7'b0100000);
    SLOW <= 1'b0;
    INJ_TRIG_EN <= 1'b1;
    INJ_TRIG_SEL <= 3'h6;
    on(1'b1);
    wt(0);
    trig(8'h40);
    wt(4);
    wt(2);
    chk(INJ_DATA, {16'h0da5, 16'h0ca5, 16'h02a5, 16'h01a5});
    @(posedge CLOCK);
    MODE <= mode_t'(7'h00);
    REG_TRIG_EN <= 1'b1;
    REG_TRIG_SEL <= 3'h2;
    AWD_EN <= 1'b1;
    AWD_HIGH <= 12'h3a0;
    n = awd_cnt;
    trig(8'h04);
    pop(4'h3, 1'b0);
    chk(64'(awd_cnt - n), 64'h1);
    // divide by four, channel 3 samples for four working ticks
    @(posedge CLOCK);
    AWD_EN <= 1'b0;
    CLK_DIV_SEL <= 4'h3;
    SAMPLE_TIME <= 48'h400;
    on(1'b1);
    @(posedge CLOCK);
    #1;
    n = 0;
    while (ANA_SAMPLE === 1'b1 && n < 100)
    begin
      @(posedge CLOCK);
      #1;
      n++;
    end
    chk(n >= 16 && n <= 20, 1'b1);
    pop(4'h3, 1'b0);
    results();
  end
endmodule
